// [hw/scr_config_regs.sv]
// Purpose: Configuration register bank of a synthesizer, written over a serial link.
// Assumes: The host keeps the link clock still while the load strobe is high.
// Notes: Words commit on the falling load strobe that follows a rising one.
//
// Behaviour
// - Writing the fixed reset word returns every register to its default.
// - The reset acts only after the strobe rose and then fell.
// - The output-level trim resets to zero.
// - Output select 0 disables, 2 enables, otherwise the enable pin decides.
// - Three four-bit power words take 0 to 15 and reset to 12.
// - Bypass uses termination and bypass drive, else termination and divided drive.
// - Timeout 0 leaves the status pin undriven, 1 forces boost, 2 and 3 drive it low and high.
// - Timeout 4 to 16383 engages boost for twice that many detector cycles.
// - Boost grounds the status pin and selects boost pump and resistor codes.
// - Resistor codes 0 to 4 are valid; 5 to 7 are reserved.
// - Pump code n selects n+1 steps of 100 microamps.
// - Every divider-and-filter write resynchronises the output divider.
// - Divider ratio 1 to 63; 0 illegal; 1 bypasses, full chip only.
// - Frequency word written last; its commit starts oscillator calibration.
`timescale 1ns/1ps
module scr_config_regs (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial programming link
    input wire logic linkClk,
    input wire logic serialData,
    input wire logic loadStrobe,
    // Other device inputs
    input wire logic rfEnablePin,
    input wire logic phaseDetTick,
    // Output stage controls
    output logic [2:0] outputLevelTrim,
    output logic rfOutputOn,
    output logic [3:0] bypassDriveWord,
    output logic [3:0] outputTerminationLevel,
    output logic [3:0] dividedDriveLevel,
    output logic [3:0] activeDriveLevel,
    // Drift compensation
    output logic [4:0] driftCompensationCode,
    output logic driftCodeValid,
    // Acquisition boost
    output logic boostEngaged,
    output logic [4:0] pumpCurrentSel,
    output logic [5:0] pumpCurrentSteps,
    output logic [2:0] firstResistorSel,
    output logic [2:0] secondResistorSel,
    output logic resistorReserved,
    output logic boostStatusOut,
    output logic boostStatusOeN,
    // Divider and reference
    output logic [5:0] dividerRatio,
    output logic dividerBypass,
    output logic dividerIllegal,
    output logic dividerSync,
    output logic [7:0] referenceRateMhz,
    output logic referenceRateIllegal,
    // Sequencing status
    output logic calStart,
    output logic oscSetupSeen,
    output logic fixedSetupSeen
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic lsSync1;
        logic lsSync2;
        logic enSync1;
        logic enSync2;
        scr_pkg::scr_ls_state_t lsState;
        logic [31:0] word;
        logic [2:0] trim;
        logic [4:0] drift;
        logic [1:0] rfSel;
        logic [3:0] bypDrive;
        logic [3:0] term;
        logic [3:0] divDrive;
        logic [13:0] toc;
        logic [4:0] bPump;
        logic [2:0] bR3;
        logic [2:0] bR4;
        logic [2:0] nR3;
        logic [2:0] nR4;
        logic [5:0] divRatio;
        logic [7:0] refRate;
        logic [4:0] pump;
        logic [1:0] mode;
        logic oscSeen;
        logic fixedSeen;
        logic divSync;
        logic cal;
        logic boostStart;
        logic softClear;
    } scr_top_state_t;

    scr_top_state_t st;
    scr_top_state_t next_st;
    logic [31:0] shiftWord;
    logic timerEngaged;
    logic engagedAll;
    logic commit;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic resReserved(input logic [2:0] code);
        resReserved = (code > scr_pkg::RES_MAX);
    endfunction : resReserved

    // Defaults applied both at power-on and on a soft reset word.
    function automatic scr_top_state_t withDefaults(input scr_top_state_t s);
        scr_top_state_t r;
        r = s;
        r.trim = scr_pkg::TRIM_DEF;
        r.drift = 5'h00;
        r.rfSel = scr_pkg::RFSEL_OFF;
        r.bypDrive = scr_pkg::POWER_DEF;
        r.term = scr_pkg::POWER_DEF;
        r.divDrive = scr_pkg::POWER_DEF;
        r.toc = scr_pkg::TOC_DISABLED;
        r.bPump = 5'h00;
        r.bR3 = 3'h0;
        r.bR4 = 3'h0;
        r.nR3 = 3'h0;
        r.nR4 = 3'h0;
        r.divRatio = scr_pkg::DIV_DEF;
        r.refRate = 8'h00;
        r.pump = 5'h00;
        r.mode = scr_pkg::MODE_FULL;
        r.oscSeen = 1'b0;
        r.fixedSeen = 1'b0;
        withDefaults = r;
    endfunction : withDefaults

    // ------------------------------------------------------------
    // Link side and boost timer
    // ------------------------------------------------------------
    scr_serial_rx u_rx (
        .linkClk(linkClk),
        .loadStrobe(loadStrobe),
        .serialData(serialData),
        .shiftWord(shiftWord)
    );

    scr_boost_timer u_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clear(st.softClear),
        .start(st.boostStart),
        .phaseDetTick(phaseDetTick),
        .timeout(st.toc),
        .engaged(timerEngaged)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    assign commit = (st.lsState == scr_pkg::SCR_LS_HIGH) && !st.lsSync2;

    always_comb begin
        next_st = st;
        next_st.lsSync1 = loadStrobe;
        next_st.lsSync2 = st.lsSync1;
        next_st.enSync1 = rfEnablePin;
        next_st.enSync2 = st.enSync1;
        next_st.divSync = 1'b0;
        next_st.cal = 1'b0;
        next_st.boostStart = 1'b0;
        next_st.softClear = 1'b0;
        case (st.lsState)
            scr_pkg::SCR_LS_IDLE: begin
                if (st.lsSync2) begin
                    // Word is stable while the strobe is high, so it may be taken here.
                    next_st.word = shiftWord;
                    next_st.lsState = scr_pkg::SCR_LS_HIGH;
                end
            end
            scr_pkg::SCR_LS_HIGH: begin
                if (!st.lsSync2) begin
                    next_st.lsState = scr_pkg::SCR_LS_IDLE;
                end
            end
            default: begin
                next_st.lsState = scr_pkg::SCR_LS_IDLE;
            end
        endcase
        if (commit) begin
            case (st.word[3:0])
                scr_pkg::ADDR_RESET: begin
                    if (st.word == scr_pkg::RESET_WORD) begin
                        next_st = withDefaults(next_st);
                        next_st.softClear = 1'b1;
                    end
                end
                scr_pkg::ADDR_TRIM: begin
                    next_st.trim = st.word[scr_pkg::TRIM_LSB +: 3];
                end
                scr_pkg::ADDR_OSC: begin
                    next_st.oscSeen = (st.word == scr_pkg::OSC_WORD);
                end
                scr_pkg::ADDR_FIXED: begin
                    next_st.fixedSeen = (st.word == scr_pkg::FIXED_WORD);
                end
                scr_pkg::ADDR_DRIFT: begin
                    next_st.drift = st.word[scr_pkg::DRIFT_LSB +: 5];
                end
                scr_pkg::ADDR_POWER: begin
                    next_st.rfSel = st.word[scr_pkg::RFSEL_LSB +: 2];
                    next_st.divDrive = st.word[scr_pkg::DIVDRV_LSB +: 4];
                    next_st.term = st.word[scr_pkg::TERM_LSB +: 4];
                    next_st.bypDrive = st.word[scr_pkg::BYPDRV_LSB +: 4];
                end
                scr_pkg::ADDR_BOOST: begin
                    next_st.toc = st.word[scr_pkg::TOC_LSB +: 14];
                    next_st.bR3 = st.word[scr_pkg::BR3_LSB +: 3];
                    next_st.bR4 = st.word[scr_pkg::BR4_LSB +: 3];
                    next_st.bPump = st.word[scr_pkg::BPUMP_LSB +: 5];
                end
                scr_pkg::ADDR_DIVF: begin
                    next_st.refRate = st.word[scr_pkg::REF_LSB +: 8];
                    next_st.divRatio = st.word[scr_pkg::DIV_LSB +: 6];
                    next_st.nR3 = st.word[scr_pkg::NR3_LSB +: 3];
                    next_st.nR4 = st.word[scr_pkg::NR4_LSB +: 3];
                    next_st.divSync = 1'b1;
                end
                scr_pkg::ADDR_CTRL: begin
                    next_st.mode = st.word[scr_pkg::MODE_LSB +: 2];
                    next_st.pump = st.word[scr_pkg::PUMP_LSB +: 5];
                end
                scr_pkg::ADDR_FREQ: begin
                    // A frequency change recalibrates and opens a boost window.
                    next_st.cal = 1'b1;
                    next_st.boostStart = 1'b1;
                end
                default: begin
                    next_st.word = st.word;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= withDefaults('0);
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign engagedAll = (timerEngaged && st.toc >= scr_pkg::TOC_MIN) ||
                        (st.toc == scr_pkg::TOC_ALWAYS);
    assign outputLevelTrim = st.trim;
    assign bypassDriveWord = st.bypDrive;
    assign outputTerminationLevel = st.term;
    assign dividedDriveLevel = st.divDrive;
    assign driftCompensationCode = st.drift;
    assign driftCodeValid = (st.drift == scr_pkg::DRIFT_DYNAMIC) ||
                            (st.drift == scr_pkg::DRIFT_FIXED);
    assign boostEngaged = engagedAll;
    assign dividerRatio = st.divRatio;
    assign dividerSync = st.divSync;
    assign referenceRateMhz = st.refRate;
    assign referenceRateIllegal = (st.refRate == 8'h00);
    assign calStart = st.cal;
    assign oscSetupSeen = st.oscSeen;
    assign fixedSetupSeen = st.fixedSeen;
    assign dividerBypass = (st.divRatio == scr_pkg::DIV_BYPASS);
    // Bypass is only legal in full chip mode; the flag lets the output stage refuse it.
    assign dividerIllegal = (st.divRatio == scr_pkg::DIV_ILLEGAL) ||
                            (dividerBypass && st.mode != scr_pkg::MODE_FULL);

    always_comb begin
        case (st.rfSel)
            scr_pkg::RFSEL_OFF: rfOutputOn = 1'b0;
            scr_pkg::RFSEL_ON: rfOutputOn = 1'b1;
            default: rfOutputOn = st.enSync2;
        endcase
    end

    assign activeDriveLevel = dividerBypass ? st.bypDrive : st.divDrive;
    assign pumpCurrentSel = engagedAll ? st.bPump : st.pump;
    assign pumpCurrentSteps = {1'b0, pumpCurrentSel} + 6'h01;
    assign firstResistorSel = engagedAll ? st.bR3 : st.nR3;
    assign secondResistorSel = engagedAll ? st.bR4 : st.nR4;
    assign resistorReserved = resReserved(firstResistorSel) || resReserved(secondResistorSel);

    // Status pin: the enable is low while the pin is driven.
    always_comb begin
        boostStatusOut = 1'b0;
        boostStatusOeN = 1'b1;
        case (st.toc)
            scr_pkg::TOC_DISABLED: boostStatusOeN = 1'b1;
            scr_pkg::TOC_ALWAYS: boostStatusOeN = 1'b0;
            scr_pkg::TOC_LOW: boostStatusOeN = 1'b0;
            scr_pkg::TOC_HIGH: begin
                boostStatusOut = 1'b1;
                boostStatusOeN = 1'b0;
            end
            default: boostStatusOeN = !timerEngaged;
        endcase
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_reset_word_defaults: assert property (
        (commit && st.word == scr_pkg::RESET_WORD) |=>
        (st.term == scr_pkg::POWER_DEF && st.toc == scr_pkg::TOC_DISABLED && !st.fixedSeen))
        else $error("Reset word did not restore defaults.");
    a_reset_after_fall: assert property (
        (st.lsSync2 && st.lsState == scr_pkg::SCR_LS_HIGH) |=> !st.softClear)
        else $error("Soft reset acted while the strobe was high.");
    a_trim_reset_zero: assert property (
        $rose(st.softClear) |-> (st.trim == scr_pkg::TRIM_DEF))
        else $error("Trim not zero after soft reset.");
    a_rf_select_off: assert property (
        (st.rfSel == scr_pkg::RFSEL_OFF) |-> !rfOutputOn)
        else $error("Output on while select is off.");
    a_rf_pin_follow: assert property (
        (st.rfSel == 2'h1 && $stable(st.rfSel)) |-> (rfOutputOn == st.enSync2))
        else $error("Output does not follow the enable pin.");
    a_drive_select: assert property (
        !dividerBypass |-> (activeDriveLevel == st.divDrive))
        else $error("Divided drive not selected above bypass.");
    a_status_grounded: assert property (
        (timerEngaged && st.toc >= scr_pkg::TOC_MIN) |->
        (!boostStatusOeN && !boostStatusOut && pumpCurrentSel == st.bPump))
        else $error("Boost engaged without grounded pin or boost pump.");
    a_status_high: assert property (
        (st.toc == scr_pkg::TOC_HIGH) |-> (boostStatusOut && !boostStatusOeN && !boostEngaged))
        else $error("General purpose high state wrong.");
    a_pump_steps: assert property (
        pumpCurrentSteps == 6'(pumpCurrentSel) + 6'h01)
        else $error("Pump current steps wrong.");
    a_divider_sync: assert property (
        (commit && st.word[3:0] == scr_pkg::ADDR_DIVF) |=> dividerSync ##1 !dividerSync)
        else $error("Divider sync pulse missing or long.");
    a_cal_on_freq: assert property (
        (commit && st.word[3:0] == scr_pkg::ADDR_FREQ) |=> calStart)
        else $error("Calibration not started by frequency word.");
    a_divider_zero: assert property (
        (st.divRatio == scr_pkg::DIV_ILLEGAL) |-> dividerIllegal)
        else $error("Zero divider not flagged.");

    c_soft_reset: cover property (commit && st.word == scr_pkg::RESET_WORD);
    c_boost_run: cover property (st.cal ##1 timerEngaged [*8]);
    c_pin_follow: cover property (st.rfSel == 2'h1 && rfOutputOn);
    c_div_sync: cover property (dividerSync);
endmodule : scr_config_regs

// [hw/scr_pkg.sv]
// Purpose: Shared constants for the synthesizer configuration register bank.
// Assumes: 32-bit serial words, register select in the low four bits.
// Notes: Field positions give the least significant bit of each field.
package scr_pkg;
    // ------------------------------------------------------------
    // Word layout and register selects
    // ------------------------------------------------------------
    localparam int unsigned WORD_W = 32;
    localparam logic [3:0] ADDR_FREQ = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h3;
    localparam logic [3:0] ADDR_DIVF = 4'h4;
    localparam logic [3:0] ADDR_BOOST = 4'h5;
    localparam logic [3:0] ADDR_POWER = 4'h6;
    localparam logic [3:0] ADDR_RESET = 4'h7;
    localparam logic [3:0] ADDR_DRIFT = 4'h8;
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [3:0] ADDR_OSC = 4'hC;
    localparam logic [3:0] ADDR_TRIM = 4'hD;
    // ------------------------------------------------------------
    // Fixed words
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_WORD = 32'h00000017;
    localparam logic [31:0] OSC_WORD = 32'h0000001C;
    localparam logic [31:0] FIXED_WORD = 32'h28001409;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned TRIM_LSB = 4;
    localparam int unsigned DRIFT_LSB = 4;
    localparam int unsigned RFSEL_LSB = 4;
    localparam int unsigned DIVDRV_LSB = 6;
    localparam int unsigned TERM_LSB = 10;
    localparam int unsigned BYPDRV_LSB = 14;
    localparam int unsigned TOC_LSB = 4;
    localparam int unsigned BR3_LSB = 18;
    localparam int unsigned BR4_LSB = 21;
    localparam int unsigned BPUMP_LSB = 24;
    localparam int unsigned REF_LSB = 4;
    localparam int unsigned DIV_LSB = 12;
    localparam int unsigned NR3_LSB = 18;
    localparam int unsigned NR4_LSB = 21;
    localparam int unsigned MODE_LSB = 4;
    localparam int unsigned PUMP_LSB = 8;
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [3:0] POWER_DEF = 4'hC;
    localparam logic [2:0] TRIM_DEF = 3'h0;
    localparam logic [5:0] DIV_DEF = 6'h01;
    localparam logic [13:0] TOC_DISABLED = 14'h0000;
    localparam logic [13:0] TOC_ALWAYS = 14'h0001;
    localparam logic [13:0] TOC_LOW = 14'h0002;
    localparam logic [13:0] TOC_HIGH = 14'h0003;
    localparam logic [13:0] TOC_MIN = 14'h0004;
    localparam logic [1:0] RFSEL_OFF = 2'h0;
    localparam logic [1:0] RFSEL_ON = 2'h2;
    localparam logic [4:0] DRIFT_DYNAMIC = 5'h05;
    localparam logic [4:0] DRIFT_FIXED = 5'h18;
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [2:0] RES_MAX = 3'h4;
    localparam logic [5:0] DIV_BYPASS = 6'h01;
    localparam logic [5:0] DIV_ILLEGAL = 6'h00;

    typedef enum logic [0:0] {
        SCR_LS_IDLE = 1'b0,
        SCR_LS_HIGH = 1'b1
    } scr_ls_state_t;
endpackage : scr_pkg

// [hw/scr_serial_rx.sv]
// Purpose: Link-side shift register for the three-wire programming link.
// Assumes: Data is sampled on the rising link clock edge, most significant bit first.
// Notes: The link clock may stop outside frames, so this holds no reset.
`timescale 1ns/1ps
module scr_serial_rx (
    // Link pins
    input wire logic linkClk,
    input wire logic loadStrobe,
    input wire logic serialData,
    // Word towards the system domain
    output logic [31:0] shiftWord
);
    typedef struct packed {
        logic [31:0] shift;
    } scr_rx_state_t;

    scr_rx_state_t st;
    scr_rx_state_t next_st;

    // The word is frozen while the strobe is high, which is what makes the capture safe.
    always_comb begin
        next_st = st;
        if (!loadStrobe) begin
            next_st.shift = {st.shift[30:0], serialData};
        end
    end

    always_ff @(posedge linkClk) begin
        st <= next_st;
    end

    assign shiftWord = st.shift;

    a_shift_frozen: assert property (@(posedge linkClk)
        loadStrobe |=> $stable(st.shift))
        else $error("Shift word moved while the strobe was high.");
    a_shift_entry: assert property (@(posedge linkClk)
        !loadStrobe |=> (st.shift[0] == $past(serialData)))
        else $error("Shift word did not take the sampled data bit.");
endmodule : scr_serial_rx

// [hw/scr_boost_timer.sv]
// Purpose: Acquisition boost timeout counter on the system clock, stepped by phase-detector ticks.
// Assumes: phaseDetTick is a one-cycle pulse per phase-detector cycle.
// Notes: A restart while running reloads the full count.
`timescale 1ns/1ps
module scr_boost_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic clear,
    input wire logic start,
    input wire logic phaseDetTick,
    input wire logic [13:0] timeout,
    // Status
    output logic engaged
);
    typedef struct packed {
        logic [14:0] remaining;
    } scr_tmr_state_t;

    scr_tmr_state_t st;
    scr_tmr_state_t next_st;

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.remaining = 15'h0000;
        end else if (start && timeout >= scr_pkg::TOC_MIN) begin
            next_st.remaining = {timeout, 1'b0};
        end else if (start) begin
            next_st.remaining = 15'h0000;
        end else if (phaseDetTick && st.remaining != 15'h0000) begin
            next_st.remaining = st.remaining - 15'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign engaged = (st.remaining != 15'h0000);

    a_boost_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (start && !clear && timeout >= scr_pkg::TOC_MIN) |=> (st.remaining == {$past(timeout), 1'b0}))
        else $error("Boost count not loaded with twice the timeout.");
    a_boost_small: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (start && timeout < scr_pkg::TOC_MIN) |=> !engaged)
        else $error("Boost counter ran for a small timeout.");
    c_boost_expire: cover property (@(posedge clk_sys) disable iff (sys_rst)
        engaged ##1 !engaged);
endmodule : scr_boost_timer

// [tb/scr_host_model.sv]
// Purpose: Host model driving the three-wire programming link.
// Assumes: Words are 32 bits, sent most significant bit first.
// Notes: The link clock stands still between frames.
`timescale 1ns/1ps
module scr_host_model (
    // Link pins
    output logic linkClk,
    output logic serialData,
    output logic loadStrobe
);
    initial begin
        linkClk = 1'b0;
        serialData = 1'b0;
        loadStrobe = 1'b0;
    end
    // The strobe stays high well past four system clocks, so the synchroniser sees it.
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            serialData = w[i];
            #16 linkClk = 1'b1;
            #16 linkClk = 1'b0;
        end
        serialData = ~w[0];
        #16 loadStrobe = 1'b1;
        #200 loadStrobe = 1'b0;
        #250;
    endtask : send
endmodule : scr_host_model

// [tb/synth_config_regs_boost_timer_test.sv]
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: The host model commits each word before send returns.
// Notes: Fixed waits only where the boost count or the enable pin synchroniser fixes them.
`timescale 1ns/1ps
module synth_config_regs_boost_timer_test;
    logic clk_sys, sys_rst, rfEnablePin, phaseDetTick, linkClk, serialData, loadStrobe;
    logic rfOutputOn, boostEngaged, boostStatusOut, boostStatusOeN, driftCodeValid;
    logic dividerBypass, dividerIllegal, dividerSync, calStart, oscSetupSeen, fixedSetupSeen;
    logic resistorReserved, referenceRateIllegal;
    logic [2:0] outputLevelTrim, firstResistorSel, secondResistorSel;
    logic [3:0] bypassDriveWord, activeDriveLevel, outputTerminationLevel, dividedDriveLevel;
    logic [4:0] driftCompensationCode, pumpCurrentSel;
    logic [5:0] dividerRatio, pumpCurrentSteps;
    logic [7:0] referenceRateMhz;
    int fails = 0;
    int tests_run = 0;
    int syncSeen = 0;
    int calSeen = 0;
    scr_host_model u_scr_host_model (.linkClk(linkClk), .serialData(serialData),
        .loadStrobe(loadStrobe));
    scr_config_regs u_scr_config_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .linkClk(linkClk), .serialData(serialData), .loadStrobe(loadStrobe),
        .rfEnablePin(rfEnablePin), .phaseDetTick(phaseDetTick),
        .outputLevelTrim(outputLevelTrim), .rfOutputOn(rfOutputOn),
        .bypassDriveWord(bypassDriveWord), .outputTerminationLevel(outputTerminationLevel),
        .dividedDriveLevel(dividedDriveLevel), .activeDriveLevel(activeDriveLevel),
        .driftCompensationCode(driftCompensationCode), .driftCodeValid(driftCodeValid),
        .boostEngaged(boostEngaged), .pumpCurrentSel(pumpCurrentSel),
        .pumpCurrentSteps(pumpCurrentSteps), .firstResistorSel(firstResistorSel),
        .secondResistorSel(secondResistorSel), .resistorReserved(resistorReserved),
        .boostStatusOut(boostStatusOut), .boostStatusOeN(boostStatusOeN),
        .dividerRatio(dividerRatio), .dividerBypass(dividerBypass),
        .dividerIllegal(dividerIllegal), .dividerSync(dividerSync),
        .referenceRateMhz(referenceRateMhz), .referenceRateIllegal(referenceRateIllegal),
        .calStart(calStart), .oscSetupSeen(oscSetupSeen), .fixedSetupSeen(fixedSetupSeen));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Pulses last one cycle, so they are counted at the falling edge where they stand.
    always @(negedge clk_sys) begin
        if (dividerSync === 1'b1) syncSeen++;
        if (calStart === 1'b1) calSeen++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] w);
        u_scr_host_model.send(w);
        @(negedge clk_sys);
    endtask : wr
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk_sys) phaseDetTick = 1'b1;
            @(negedge clk_sys) phaseDetTick = 1'b0;
        end
    endtask : ticks
    task automatic t_defaults();
        chk(outputLevelTrim, 0);
        chk(bypassDriveWord, 12);
        chk({outputTerminationLevel, dividedDriveLevel}, 8'hCC);
        chk(dividerRatio, 1);
        chk(boostStatusOeN, 1);
        chk(rfOutputOn, 0);
    endtask : t_defaults
    task automatic t_power();
        wr(32'h00000017);
        wr(32'h0000001C);
        wr(32'h28001409);
        chk({oscSetupSeen, fixedSetupSeen}, 2'h3);
        wr(32'h00017CE6);
        chk(rfOutputOn, 1);
        chk(activeDriveLevel, 5);
        chk({outputTerminationLevel, dividedDriveLevel}, 8'hF3);
        wr(32'h001F7CE6);
        wr(32'h000000CD);
        chk({outputLevelTrim, activeDriveLevel}, 7'h4D);
        wr(32'h00017CD6);
        chk(rfOutputOn, 0);
        rfEnablePin = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(rfOutputOn, 1);
        wr(32'h000040A4);
        chk(dividerRatio, 4);
        chk(syncSeen, 1);
        chk({dividerBypass, dividerIllegal}, 0);
        chk({referenceRateMhz, referenceRateIllegal}, 9'h014);
        chk(activeDriveLevel, 3);
        wr(32'h00000188);
        chk({driftCompensationCode, driftCodeValid}, 6'h31);
    endtask : t_power
    task automatic t_boost();
        wr(32'h1F300045);
        wr(32'h00000000);
        chk(calSeen, 1);
        chk(boostEngaged, 1);
        chk(boostStatusOeN, 0);
        chk({pumpCurrentSel, pumpCurrentSteps}, 11'h7E0);
        chk(firstResistorSel, 4);
        chk({secondResistorSel, resistorReserved}, 4'h2);
        ticks(7);
        chk(boostEngaged, 1);
        ticks(1);
        chk(boostEngaged, 0);
        chk(boostStatusOeN, 1);
        chk(pumpCurrentSteps, 1);
        wr(32'h1F300035);
        chk({boostStatusOeN, boostStatusOut}, 1);
    endtask : t_boost
    task automatic t_reset();
        wr(32'h00000017);
        chk(dividerRatio, 1);
        chk(bypassDriveWord, 12);
        chk(boostStatusOeN, 1);
        chk({oscSetupSeen, fixedSetupSeen, driftCompensationCode}, 0);
        wr(32'h00000013);
        chk({dividerBypass, dividerIllegal}, 2'h3);
    endtask : t_reset
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        sys_rst = 1'b1;
        rfEnablePin = 1'b0;
        phaseDetTick = 1'b0;
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        t_defaults();
        t_power();
        t_boost();
        t_reset();
        end_sim();
    end
endmodule : synth_config_regs_boost_timer_test
